// *** src/uhp_pkg.sv ***
// Constants shared by the host port state manager and its helpers.
// Assumes a single 125 MHz system clock and a byte-addressed register bus.
//
// What this block does
// - Resume end or command enters operational
// - Operational: normal xcvr, transactions, disconnect detect
// - Suspend command accepted only from operational
// - Suspend: detection off, finish transaction, halt
// - Suspend: high speed drops to full; power-down
// - After interval: disconnect on, wakeup if permitted
// - Suspended: K held 2.5 us flags wakeup
// - Resume from suspend; both detectors disabled
// - Resume drives K, restores speed, flags completion
// - Fault pin falling edge raises VBUS error flag
// - Cancel bit self-clears after stop processing
// - Idle switches bus power enable off
// - Disconnect detection in operational and suspend
// - High-speed disconnect sampled only when operational
// - Three bad SOF end samples flag disconnect
// - Full/low speed: SE0 over 2.5 us
// - Idle halts, full speed, non-driving, detection off
package uhp_pkg;
    localparam int CLK_MHZ = 125;
    localparam int ADDR_W = 5;

    localparam logic [4:0] OFS_CMD = 5'h00;
    localparam logic [4:0] OFS_NEGO = 5'h04;
    localparam logic [4:0] OFS_STAT_A = 5'h08;
    localparam logic [4:0] OFS_STAT_B = 5'h0C;
    localparam logic [4:0] OFS_HOST = 5'h10;
    localparam logic [4:0] OFS_MON = 5'h14;

    localparam int CANCEL_BIT = 7;
    localparam logic [3:0] CMD_NONE = 4'h0;
    localparam logic [3:0] CMD_GO_IDLE = 4'h1;
    localparam logic [3:0] CMD_GO_ATTACH = 4'h2;
    localparam logic [3:0] CMD_GO_OPER = 4'h3;
    localparam logic [3:0] CMD_GO_SUSP = 4'h4;
    localparam logic [3:0] CMD_GO_RESUME = 4'h5;

    localparam logic [1:0] SPD_HS = 2'h0;
    localparam logic [1:0] SPD_FS = 2'h1;
    localparam logic [1:0] SPD_LS = 2'h2;
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [1:0] OPM_NONDRIVE = 2'h1;
    localparam logic [1:0] OPM_PWRDN = 2'h3;
    localparam logic [1:0] LINE_SE0 = 2'h0;
    localparam logic [1:0] LINE_K = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ATTACH = 5'h02,
        ST_OPER = 5'h04,
        ST_SUSP = 5'h08,
        ST_RESUME = 5'h10
    } uhp_state_t;

    localparam logic [2:0] MON_IDLE = 3'h0;
    localparam logic [2:0] MON_ATTACH = 3'h1;
    localparam logic [2:0] MON_OPER = 3'h5;
    localparam logic [2:0] MON_SUSP = 3'h6;
    localparam logic [2:0] MON_RESUME = 3'h7;

    localparam logic [1:0] PH_NONE = 2'h0;
    localparam logic [1:0] PH_WAIT_TXN = 2'h1;
    localparam logic [1:0] PH_DET_OFF = 2'h2;

    localparam int FILTER_NS = 2500;
    localparam int FILTER_CYCLES = (FILTER_NS * CLK_MHZ) / 1000 + 1;
    localparam int CANCEL_NS = 100;
    localparam int CANCEL_CYCLES = (CANCEL_NS * CLK_MHZ + 999) / 1000;
    localparam int HS_DISC_SAMPLES = 3;
    localparam int RESUME_K_US = 20;
    localparam int RESUME_K_CYCLES = RESUME_K_US * CLK_MHZ;
    localparam int DET_OFF_US = 10;
    localparam int DET_OFF_CYCLES = DET_OFF_US * CLK_MHZ;
endpackage : uhp_pkg

// *** src/uhp_sync2.sv ***
// Two-flop synchroniser for pins from outside the system clock domain.
// Assumes the inputs are levels that stay put for several clock cycles.
`timescale 1ns/100ps
`default_nettype none
module uhp_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : uhp_sync2
`default_nettype wire

// *** src/uhp_persist.sv ***
// Pulses once when a condition has held for CYCLES consecutive clocks.
// Assumes cond is already synchronous; dropping enable restarts the count.
`timescale 1ns/100ps
`default_nettype none
module uhp_persist #(
    parameter int CYCLES = 313
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic cond,
    output logic hit
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic hit_next;

    if (CYCLES < 2) begin : g_chk
        $error("uhp_persist: CYCLES must be at least 2");
    end

    always_comb begin
        cnt_next = cnt_reg;
        hit_next = 1'b0;
        if (!enable || !cond) begin
            cnt_next = '0;
        end else if (cnt_reg == CW'(CYCLES - 1)) begin
            // Saturate so one long condition yields a single pulse
            cnt_next = CW'(CYCLES);
            hit_next = 1'b1;
        end else if (cnt_reg != CW'(CYCLES)) begin
            cnt_next = cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            hit <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            hit <= hit_next;
        end
    end
endmodule : uhp_persist
`default_nettype wire

// *** src/uhp_port_state_manager.sv ***
// Downstream host port state manager with Avalon-MM register slave.
// Assumes txn_busy, sof_eop_pulse and attached_speed come from logic on
// sys_clk; the fault pin, line state and HS disconnect comparator do not.
`timescale 1ns/100ps
`default_nettype none
module uhp_port_state_manager
    import uhp_pkg::*;
#(
    parameter int RESUME_CYCLES = RESUME_K_CYCLES,
    parameter int DET_OFF_TIME = DET_OFF_CYCLES,
    parameter int TMR_W = 22
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic power_switch_fault_in,
    input wire logic [1:0] cable_line_state,
    input wire logic hs_disconnect_in,
    input wire logic sof_eop_pulse,
    input wire logic txn_busy,
    input wire logic [1:0] attached_speed,
    output logic bus_power_enable_out,
    output logic [1:0] transceiver_speed_select,
    output logic termination_select,
    output logic [1:0] transceiver_op_mode,
    output logic txn_enable,
    output logic drive_resume_k
);
    localparam int CXL_MAX = CANCEL_CYCLES + 1;

    if (RESUME_CYCLES < 1 || RESUME_CYCLES >= 2**TMR_W ||
        DET_OFF_TIME < 1 || DET_OFF_TIME >= 2**TMR_W) begin : g_chk
        $error("uhp_port_state_manager: interval does not fit timer");
    end

    logic fault_s;
    logic [1:0] line_s;
    logic hs_disc_s;
    logic se0_hit;
    logic k_hit;

    uhp_sync2 #(.W(4), .RST_VAL(4'hA)) u_sync ( // No fault, J, connected
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .d({power_switch_fault_in, cable_line_state, hs_disconnect_in}),
        .q({fault_s, line_s, hs_disc_s})
    );

    uhp_state_t state_reg, state_next;
    logic [3:0] cmd_field_reg, cmd_field_next;
    logic cancel_reg, cancel_next;
    logic [4:0] cancel_cnt_reg, cancel_cnt_next;
    logic wake_perm_reg, wake_perm_next;
    logic [TMR_W-1:0] timer_reg, timer_next;
    logic [1:0] phase_reg, phase_next;
    logic [1:0] saved_speed_reg, saved_speed_next;
    logic [1:0] speed_next, transceiver_op_mode_next;
    logic term_next, power_next, txn_en_next, drive_k_next;
    logic disc_en_reg, disc_en_next;
    logic wake_en_reg, wake_en_next;
    logic [1:0] hs_cnt_reg, hs_cnt_next;
    logic disc_flag_reg, disc_flag_next;
    logic wake_flag_reg, wake_flag_next;
    logic susp_cmp_reg, susp_cmp_next;
    logic res_cmp_reg, res_cmp_next;
    logic vbus_flag_reg, vbus_flag_next;
    logic fault_prev_reg;
    logic wait_next;
    logic [31:0] rdata_next;
    logic access, wr_lo, hs_hit;
    logic [2:0] mon_code;

    // Full/low speed disconnect: SE0 on the line longer than the filter
    uhp_persist #(.CYCLES(FILTER_CYCLES)) u_se0 (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .enable(disc_en_reg && transceiver_speed_select != SPD_HS &&
                (state_reg == ST_OPER || state_reg == ST_SUSP)),
        .cond(line_s == LINE_SE0),
        .hit(se0_hit)
    );

    // Remote wakeup: K held on the line while suspended
    uhp_persist #(.CYCLES(FILTER_CYCLES)) u_kwake (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .enable(state_reg == ST_SUSP && wake_en_reg && wake_perm_reg),
        .cond(line_s == LINE_K),
        .hit(k_hit)
    );

    always_comb begin
        unique case (state_reg)
            ST_IDLE: mon_code = MON_IDLE;
            ST_ATTACH: mon_code = MON_ATTACH;
            ST_OPER: mon_code = MON_OPER;
            ST_SUSP: mon_code = MON_SUSP;
            ST_RESUME: mon_code = MON_RESUME;
            default: mon_code = MON_IDLE;
        endcase
    end

    assign access = (avs_read || avs_write) && !avs_waitrequest;
    assign wr_lo = access && avs_write && avs_byteenable[0];
    assign hs_hit = state_reg == ST_OPER && disc_en_reg &&
                    transceiver_speed_select == SPD_HS && sof_eop_pulse &&
                    hs_disc_s && hs_cnt_reg == 2'(HS_DISC_SAMPLES - 1);

    always_comb begin
        state_next = state_reg;
        cmd_field_next = cmd_field_reg;
        cancel_next = cancel_reg;
        cancel_cnt_next = cancel_cnt_reg;
        wake_perm_next = wake_perm_reg;
        timer_next = timer_reg;
        phase_next = phase_reg;
        saved_speed_next = saved_speed_reg;
        speed_next = transceiver_speed_select;
        transceiver_op_mode_next = transceiver_op_mode;
        power_next = bus_power_enable_out;
        txn_en_next = txn_enable;
        drive_k_next = drive_resume_k;
        disc_en_next = disc_en_reg;
        wake_en_next = wake_en_reg;
        hs_cnt_next = hs_cnt_reg;
        disc_flag_next = disc_flag_reg;
        wake_flag_next = wake_flag_reg;
        susp_cmp_next = susp_cmp_reg;
        res_cmp_next = res_cmp_reg;
        vbus_flag_next = vbus_flag_reg;
        // One-cycle wait on every request, then a single ready cycle
        wait_next = !((avs_read || avs_write) && avs_waitrequest);
        rdata_next = avs_readdata;

        if ((avs_read || avs_write) && avs_waitrequest) begin
            rdata_next = '0;
            case (avs_address)
                OFS_CMD: rdata_next[7:0] = {cancel_reg, 3'h0, cmd_field_reg};
                OFS_NEGO: rdata_next[2:0] = {attached_speed, wake_perm_reg};
                OFS_STAT_A: rdata_next[1:0] = {wake_flag_reg, disc_flag_reg};
                OFS_STAT_B: rdata_next[1:0] = {res_cmp_reg, susp_cmp_reg};
                OFS_HOST: rdata_next[0] = vbus_flag_reg;
                OFS_MON: rdata_next[10:0] = {wake_en_reg, disc_en_reg,
                    txn_enable, bus_power_enable_out, transceiver_op_mode,
                    transceiver_speed_select, mon_code};
                default: rdata_next = '0;
            endcase
        end

        // Status bits: write one to clear; a same-cycle event wins below
        if (wr_lo && avs_address == OFS_STAT_A) begin
            if (avs_writedata[0]) disc_flag_next = 1'b0;
            if (avs_writedata[1]) wake_flag_next = 1'b0;
        end
        if (wr_lo && avs_address == OFS_STAT_B) begin
            if (avs_writedata[0]) susp_cmp_next = 1'b0;
            if (avs_writedata[1]) res_cmp_next = 1'b0;
        end
        if (wr_lo && avs_address == OFS_HOST && avs_writedata[0]) begin
            vbus_flag_next = 1'b0;
        end
        if (wr_lo && avs_address == OFS_NEGO) begin
            wake_perm_next = avs_writedata[0];
        end

        // Sequencing inside suspend and resume
        if (state_reg == ST_SUSP && phase_reg == PH_WAIT_TXN && !txn_busy) begin
            txn_en_next = 1'b0;
            transceiver_op_mode_next = OPM_PWRDN;
            timer_next = TMR_W'(DET_OFF_TIME);
            phase_next = PH_DET_OFF;
        end
        if (state_reg == ST_SUSP && phase_reg == PH_DET_OFF) begin
            timer_next = timer_reg - TMR_W'(1);
            if (timer_reg == TMR_W'(1)) begin
                disc_en_next = 1'b1;
                wake_en_next = wake_perm_reg;
                susp_cmp_next = 1'b1;
                phase_next = PH_NONE;
            end
        end
        if (state_reg == ST_RESUME) begin
            timer_next = timer_reg - TMR_W'(1);
            if (timer_reg == TMR_W'(1)) begin
                drive_k_next = 1'b0;
                speed_next = saved_speed_reg;
                transceiver_op_mode_next = OPM_NORMAL;
                res_cmp_next = 1'b1;
                state_next = ST_OPER;
                txn_en_next = 1'b1;
                disc_en_next = 1'b1;
            end
        end

        // Cancel: stop whatever sequence runs, then release the bit
        if (cancel_reg) begin
            cancel_cnt_next = cancel_cnt_reg - 5'h1;
            if (cancel_cnt_reg == 5'h1) begin
                cancel_next = 1'b0;
                txn_en_next = 1'b0;
                drive_k_next = 1'b0;
                phase_next = PH_NONE;
                timer_next = '0;
            end
        end

        if (wr_lo && avs_address == OFS_CMD) begin
            if (avs_writedata[CANCEL_BIT]) begin
                cancel_next = 1'b1;
                cancel_cnt_next = 5'(CANCEL_CYCLES);
                cmd_field_next = avs_writedata[3:0];
            end else if (!cancel_reg) begin
                // Commands are ignored while a cancel is still running
                cmd_field_next = avs_writedata[3:0];
                case (avs_writedata[3:0])
                    CMD_GO_IDLE: begin
                        state_next = ST_IDLE;
                        txn_en_next = 1'b0;
                        speed_next = SPD_FS;
                        transceiver_op_mode_next = OPM_NONDRIVE;
                        power_next = 1'b0;
                        disc_en_next = 1'b0;
                        wake_en_next = 1'b0;
                        drive_k_next = 1'b0;
                        phase_next = PH_NONE;
                    end
                    CMD_GO_ATTACH: begin
                        state_next = ST_ATTACH;
                        txn_en_next = 1'b0;
                        speed_next = SPD_FS;
                        transceiver_op_mode_next = OPM_PWRDN;
                        power_next = 1'b1;
                        disc_en_next = 1'b0;
                        wake_en_next = 1'b0;
                        drive_k_next = 1'b0;
                        phase_next = PH_NONE;
                    end
                    CMD_GO_OPER: begin
                        state_next = ST_OPER;
                        speed_next = attached_speed;
                        transceiver_op_mode_next = OPM_NORMAL;
                        txn_en_next = 1'b1;
                        disc_en_next = 1'b1;
                        wake_en_next = 1'b0;
                        drive_k_next = 1'b0;
                        phase_next = PH_NONE;
                    end
                    CMD_GO_SUSP: begin
                        if (state_reg == ST_OPER) begin
                            state_next = ST_SUSP;
                            disc_en_next = 1'b0;
                            wake_en_next = 1'b0;
                            phase_next = PH_WAIT_TXN;
                            saved_speed_next = transceiver_speed_select;
                            if (transceiver_speed_select == SPD_HS) begin
                                speed_next = SPD_FS;
                            end
                        end
                    end
                    CMD_GO_RESUME: begin
                        if (state_reg == ST_SUSP) begin
                            state_next = ST_RESUME;
                            disc_en_next = 1'b0;
                            wake_en_next = 1'b0;
                            transceiver_op_mode_next = OPM_NORMAL;
                            drive_k_next = 1'b1;
                            timer_next = TMR_W'(RESUME_CYCLES);
                            phase_next = PH_NONE;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // High-speed disconnect: consecutive bad samples at SOF end
        if (state_reg != ST_OPER || transceiver_speed_select != SPD_HS ||
            !disc_en_reg) begin
            hs_cnt_next = 2'h0;
        end else if (sof_eop_pulse) begin
            hs_cnt_next = hs_disc_s && !hs_hit ? hs_cnt_reg + 2'h1 : 2'h0;
        end

        // Events set last so they win over a clear in the same cycle
        if (hs_hit || se0_hit) disc_flag_next = 1'b1;
        if (k_hit) wake_flag_next = 1'b1;
        if (fault_prev_reg && !fault_s) vbus_flag_next = 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cmd_field_reg <= CMD_NONE;
            cancel_reg <= 1'b0;
            cancel_cnt_reg <= 5'h0;
            wake_perm_reg <= 1'b0;
            timer_reg <= '0;
            phase_reg <= PH_NONE;
            saved_speed_reg <= SPD_FS;
            transceiver_speed_select <= SPD_FS;
            termination_select <= 1'b1;
            transceiver_op_mode <= OPM_NONDRIVE;
            bus_power_enable_out <= 1'b0;
            txn_enable <= 1'b0;
            drive_resume_k <= 1'b0;
            disc_en_reg <= 1'b0;
            wake_en_reg <= 1'b0;
            hs_cnt_reg <= 2'h0;
            disc_flag_reg <= 1'b0;
            wake_flag_reg <= 1'b0;
            susp_cmp_reg <= 1'b0;
            res_cmp_reg <= 1'b0;
            vbus_flag_reg <= 1'b0;
            fault_prev_reg <= 1'b1;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            state_reg <= state_next;
            cmd_field_reg <= cmd_field_next;
            cancel_reg <= cancel_next;
            cancel_cnt_reg <= cancel_cnt_next;
            wake_perm_reg <= wake_perm_next;
            timer_reg <= timer_next;
            phase_reg <= phase_next;
            saved_speed_reg <= saved_speed_next;
            transceiver_speed_select <= speed_next;
            termination_select <= speed_next != SPD_HS;
            transceiver_op_mode <= transceiver_op_mode_next;
            bus_power_enable_out <= power_next;
            txn_enable <= txn_en_next;
            drive_resume_k <= drive_k_next;
            disc_en_reg <= disc_en_next;
            wake_en_reg <= wake_en_next;
            hs_cnt_reg <= hs_cnt_next;
            disc_flag_reg <= disc_flag_next;
            wake_flag_reg <= wake_flag_next;
            susp_cmp_reg <= susp_cmp_next;
            res_cmp_reg <= res_cmp_next;
            vbus_flag_reg <= vbus_flag_next;
            fault_prev_reg <= fault_s;
            avs_waitrequest <= wait_next;
            avs_readdata <= rdata_next;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_enter_susp;
        $rose(state_reg == ST_SUSP);
    endsequence
    sequence s_susp_done;
        $rose(susp_cmp_reg) && state_reg == ST_SUSP;
    endsequence

    a_vbus_edge_flag: assert property (
        fault_prev_reg && !fault_s |=> vbus_flag_reg)
        else $error("VBUS error flag missed a fault edge");
    a_cancel_self_clear: assert property (
        $rose(cancel_reg) |-> ##[1:CXL_MAX] !cancel_reg)
        else $error("cancel bit did not clear");
    a_idle_power_off: assert property (
        state_reg == ST_IDLE |-> !bus_power_enable_out &&
            transceiver_op_mode == OPM_NONDRIVE)
        else $error("idle state with bus power on");
    a_oper_entry_setup: assert property (
        $rose(state_reg == ST_OPER) |-> txn_enable && disc_en_reg &&
            transceiver_op_mode == OPM_NORMAL)
        else $error("operational entry setup wrong");
    a_susp_entry_detect: assert property (
        s_enter_susp |-> !disc_en_reg && !wake_en_reg &&
            $past(state_reg) == ST_OPER)
        else $error("suspend entry left detection on");
    a_susp_done_enables: assert property (
        s_susp_done |-> disc_en_reg && wake_en_reg == wake_perm_reg &&
            !txn_enable && transceiver_op_mode == OPM_PWRDN &&
            transceiver_speed_select != SPD_HS)
        else $error("suspend completion state wrong");
    a_resume_k_drive: assert property (
        $rose(state_reg == ST_RESUME) |-> drive_resume_k &&
            !disc_en_reg && !wake_en_reg)
        else $error("resume entry wrong");
    a_resume_complete: assert property (
        $rose(res_cmp_reg) |-> state_reg == ST_OPER && !drive_resume_k &&
            transceiver_speed_select == saved_speed_reg)
        else $error("resume completion state wrong");
    a_hs_three_samples: assert property (
        $rose(disc_flag_reg) && $past(transceiver_speed_select) == SPD_HS
        |-> $past(sof_eop_pulse) && $past(hs_disc_s) &&
            $past(hs_cnt_reg) == 2'h2)
        else $error("HS disconnect flagged without three samples");
    a_wake_permitted: assert property (
        $rose(wake_flag_reg) |-> $past(wake_perm_reg, 2))
        else $error("wakeup flagged without permission");
endmodule : uhp_port_state_manager
`default_nettype wire

// *** verification/uhp_dev_model.sv ***
// Model of the device on the cable: idle J, remote wakeup K, or unplugged.
// Assumes the bench picks the mode; the port syncs these lines itself.
`timescale 1ns/100ps
`default_nettype none
module uhp_dev_model
    import uhp_pkg::*;
(
    input wire logic [1:0] mode,
    output logic [1:0] cable_line_state,
    output logic hs_disconnect_in
);
    // Unplugged lines are pulled down, so they read SE0, never the last J
    assign cable_line_state = mode == 2'h1 ? LINE_K :
        mode == 2'h2 ? LINE_SE0 : 2'h1;
    assign hs_disconnect_in = mode == 2'h2;
endmodule : uhp_dev_model
`default_nettype wire

// *** verification/tb_usb_host_port_state_manager.sv ***
// Bench for the host port state manager: a command table, then wakeup,
// disconnect and power-fault cases. Assumes resume and detect-off timers shortened to 8 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_usb_host_port_state_manager
    import uhp_pkg::*;
;
    logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
    logic fault = 1, txn_busy = 0, sof = 0, pwr, hsd, term, rk;
    logic avs_waitrequest;
    logic [4:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic [1:0] dmode = 2'h0, line, spd = SPD_FS;
    int failures = 0, tests_run = 0, n;
    logic [7:0] cmd_tab [5] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h05};
    logic [31:0] mon_tab [5] = '{32'hE9, 32'h38D, 32'h6EE, 32'h38D, 32'h38D};
    always #4 sys_clk = ~sys_clk;
    uhp_dev_model dev (.mode(dmode), .cable_line_state(line),
        .hs_disconnect_in(hsd));
    uhp_port_state_manager #(.RESUME_CYCLES(8), .DET_OFF_TIME(8)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .power_switch_fault_in(fault), .cable_line_state(line),
        .hs_disconnect_in(hsd), .sof_eop_pulse(sof), .txn_busy(txn_busy),
        .attached_speed(spd), .bus_power_enable_out(pwr),
        .transceiver_speed_select(), .termination_select(term),
        .transceiver_op_mode(), .txn_enable(), .drive_resume_k(rk));
    // Starts one edge late so a release and a new request never share a step
    task automatic bus(input logic w, input logic [4:0] a,
            input logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= ~w;
        n = 0;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && n++ < 50);
        if (n > 50) failures++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    // One-cycle SOF end marker, with at least one idle cycle before it
    task automatic sof_pulse;
        @(posedge sys_clk);
        sof <= 1'b1;
        @(posedge sys_clk);
        sof <= 1'b0;
    endtask : sof_pulse
    task automatic chk(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic ck(input string nm, input logic [4:0] a,
            input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, q, e);
    endtask : ck
    task automatic results;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        ck("mon", OFS_MON, 32'h28);
        bus(1'b1, OFS_NEGO, 8'h01);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, OFS_CMD, cmd_tab[i]);
            repeat (30) @(posedge sys_clk);
            ck("mon", OFS_MON, mon_tab[i]);
        end
        ck("stat_b", OFS_STAT_B, 32'h3);
        bus(1'b1, OFS_CMD, 8'h04);
        dmode <= 2'h1;
        repeat (360) @(posedge sys_clk);
        ck("stat_a", OFS_STAT_A, 32'h2);
        dmode <= 2'h0;
        bus(1'b1, OFS_CMD, 8'h05);
        dmode <= 2'h2;
        repeat (360) @(posedge sys_clk);
        ck("stat_a", OFS_STAT_A, 32'h3);
        dmode <= 2'h0;
        spd <= SPD_HS;
        bus(1'b1, OFS_STAT_A, 8'h03);
        bus(1'b1, OFS_CMD, 8'h03);
        bus(1'b1, OFS_CMD, 8'h04);
        repeat (30) @(posedge sys_clk);
        ck("mon", OFS_MON, 32'h6EE);
        bus(1'b1, OFS_CMD, 8'h05);
        @(posedge sys_clk);
        chk("resume_k", {31'h0, rk}, 32'h1);
        repeat (30) @(posedge sys_clk);
        chk("resume_k", {31'h0, rk}, 32'h0);
        ck("mon", OFS_MON, 32'h385);
        chk("term", {31'h0, term}, 32'h0);
        dmode <= 2'h2;
        repeat (4) @(posedge sys_clk);
        sof_pulse;
        sof_pulse;
        ck("stat_a", OFS_STAT_A, 32'h0);
        sof_pulse;
        ck("stat_a", OFS_STAT_A, 32'h1);
        fault <= 1'b0;
        // Two sync flops plus the edge detector delay the flag
        repeat (4) @(posedge sys_clk);
        ck("host", OFS_HOST, 32'h1);
        bus(1'b1, OFS_CMD, 8'h80);
        bus(1'b0, OFS_CMD, 8'h00);
        chk("cancel", {31'h0, q[7]}, 32'h1);
        for (int i = 0; i < 20 && q[7] !== 1'b0; i++)
            bus(1'b0, OFS_CMD, 8'h00);
        chk("cancel", {31'h0, q[7]}, 32'h0);
        bus(1'b1, OFS_CMD, 8'h01);
        ck("mon", OFS_MON, 32'h28);
        chk("power", {31'h0, pwr}, 32'h0);
        chk("term", {31'h0, term}, 32'h1);
        // Mid-run reset with the fault pin healthy, so no false edge
        fault <= 1'b1;
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        ck("stat_a", OFS_STAT_A, 32'h0);
        ck("mon", OFS_MON, 32'h28);
        results;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        results;
    end
endmodule : tb_usb_host_port_state_manager
`default_nettype wire
